// [bench/adm_datapath_properties.sv]
`timescale 1ns/1ps
`default_nettype none
module adm_datapath_properties #(
   parameter int OSC_PER_CYCLE = 8
) (
   input wire logic        clk_i,
   input wire logic        rst_i,
   input wire logic [3:0]  mem_addr_lo_i,
   input wire logic        memory_enable_n_i,
   input wire logic        host_window_hit_n_i,
   input wire logic        host_io_match_n_i,
   input wire logic        halt_i,
   input wire logic        host_write_n_i,
   input wire logic        host_ds0_n_i,
   input wire logic        host_ds1_n_i,
   input wire logic        mem_read_cfg_i,
   input wire logic        data_src_load_i,
   input wire logic        par_copy_clk_n_i,
   input wire logic        shadow_chain_clk_n_i,
   input wire logic        ucode_read_i,
   input wire logic        ucode_write_i,
   input wire logic        array_clk_o,
   input wire logic        mem_write_strobe_n_o,
   input wire logic [15:0] chip_sel_o,
   input wire logic        wr_rot_oe_o,
   input wire logic        rd_rot_oe_o,
   input wire logic        host_xcvr_oe_o,
   input wire logic        addr_reg_clock_o,
   input wire logic        page_reg_clock_o,
   input wire logic        data_reg_clock_o,
   input wire logic        shadow_clock_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   wire logic host = !host_window_hit_n_i && halt_i && host_io_match_n_i;
   wire logic [31:0] rot_w = {16'h000f, 16'h000f} << mem_addr_lo_i;
   logic host_q, hwr_q;
   logic [15:0] cs_q;
   // inputs one edge back, lined up with the registered outputs
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         host_q <= 1'b0;
         hwr_q  <= 1'b0;
         cs_q   <= 16'h0000;
      end else begin
         host_q <= host;
         hwr_q  <= host && !host_write_n_i;
         cs_q   <= rot_w[31:16];
      end
   end
   sequence s_par_rise;
      $rose(par_copy_clk_n_i) && !ucode_read_i;
   endsequence
   sequence s_three_clks;
      addr_reg_clock_o && page_reg_clock_o && data_reg_clock_o;
   endsequence
   a_rot_host_off: assert property (host |=> !wr_rot_oe_o && !rd_rot_oe_o)
      else $error("rotator enabled in host access");
   a_wr_rot_strobe: assert property (wr_rot_oe_o |-> !mem_write_strobe_n_o && !host_q)
      else $error("write rotator on without strobe");
   a_wr_rot_on: assert property (!mem_write_strobe_n_o && !host_q |-> wr_rot_oe_o)
      else $error("write rotator off during strobe");
   a_rd_rot_on: assert property (mem_read_cfg_i && !data_src_load_i && !host |=> rd_rot_oe_o)
      else $error("read rotator off while reading");
   a_strobe_last: assert property (!mem_write_strobe_n_o |=> mem_write_strobe_n_o && $rose(array_clk_o))
      else $error("strobe not in final period");
   a_chip_count: assert property (!mem_write_strobe_n_o && chip_sel_o != 16'h0000
      |-> $countones(chip_sel_o) == 2 || $countones(chip_sel_o) == 4)
      else $error("write selects wrong chip count");
   a_host_rd_xcvr: assert property (host && host_write_n_i |=> host_xcvr_oe_o)
      else $error("read transceiver off");
   a_host_wr_xcvr: assert property (host_xcvr_oe_o && hwr_q |-> !mem_write_strobe_n_o)
      else $error("write transceiver on early");
   a_par_copy_clks: assert property (s_par_rise |-> ##[1:2] s_three_clks)
      else $error("register clocks missing");
   a_shadow_clk: assert property ($rose(shadow_chain_clk_n_i) && !ucode_write_i |-> ##[1:2] shadow_clock_o)
      else $error("shadow clock missing");
   a_shadow_block: assert property ($rose(shadow_chain_clk_n_i) && ucode_write_i |=> !shadow_clock_o [*2])
      else $error("shadow clock in microcode write");
   a_cs_off: assert property (memory_enable_n_i && !(host && !(host_ds0_n_i && host_ds1_n_i))
      |=> chip_sel_o == 16'h0000)
      else $error("chip select while disabled");
   a_cs_array: assert property (!memory_enable_n_i && !host |=> chip_sel_o == cs_q)
      else $error("array chip select wrong");
endmodule : adm_datapath_properties
bind adm_datapath adm_datapath_properties #(.OSC_PER_CYCLE(OSC_PER_CYCLE)) u_props (.*);
`default_nettype wire

// [bench/adm_ram_model.sv]
`timescale 1ns/1ps
`default_nettype none
// one row of sixteen nibble chips; undriven or deselected lines read inverted
module adm_ram_model (
   input  wire logic        clk_i,
   input  wire logic        we_n_i,
   input  wire logic        oe_i,
   input  wire logic [15:0] cs_i,
   input  wire logic [63:0] d_i,
   output logic      [63:0] q_o
);
   logic [63:0] mem_q;
   logic [63:0] bus;
   assign bus = oe_i ? d_i : ~mem_q;
   always_ff @(posedge clk_i) begin
      for (int c = 0; c < 16; c++) begin
         if (!we_n_i && cs_i[c])
            mem_q[4*c +: 4] <= bus[4*c +: 4];
      end
   end
   always_comb begin
      for (int c = 0; c < 16; c++) begin
         q_o[4*c +: 4] = cs_i[c] ? mem_q[4*c +: 4] : ~mem_q[4*c +: 4];
      end
   end
endmodule : adm_ram_model
`default_nettype wire

// [bench/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic        clk_i, rst_i, memory_enable_n_i, host_window_hit_n_i, host_io_match_n_i, halt_i;
   logic        host_write_n_i, host_ds0_n_i, host_ds1_n_i, array_write_i, mem_read_cfg_i, ucode_read_i;
   logic        data_src_load_i, load_addr_bit_n_i, load_page_bit_n_i, load_data_bit_n_i, ucode_write_i;
   logic        copy_to_parallel_mode_n_i, copy_to_shadow_mode_n_i, par_copy_clk_n_i, chain_sdi_i;
   logic        shadow_chain_clk_n_i, chain_sdo_o, array_clk_o, mem_write_strobe_n_o, wr_rot_oe_o;
   logic        rd_rot_oe_o, host_xcvr_oe_o, addr_reg_clock_o, page_reg_clock_o, data_reg_clock_o;
   logic        shadow_clock_o, combined_mode_o;
   logic [3:0]  mem_addr_lo_i;
   logic [7:0]  page_reg_o;
   logic [15:0] addr_bus_i, data_bus_i, host_data_i, host_data_o, chip_sel_o, mem_addr_reg_o, mem_data_reg_o;
   logic [15:0] v, w;
   logic [39:0] x;
   logic [63:0] ram_data_i, ram_data_o;
   int          seed = 16;
   int          failures = 0;
   int          n_tests = 0;
   // short array cycle keeps the run brief
   adm_datapath #(.OSC_PER_CYCLE(4)) dut (.*);
   adm_ram_model u_ram (.clk_i(clk_i), .we_n_i(mem_write_strobe_n_o), .oe_i(wr_rot_oe_o | host_xcvr_oe_o),
      .cs_i(chip_sel_o), .d_i(ram_data_o), .q_o(ram_data_i));
   initial begin
      clk_i = 1'b0;
      forever #10 clk_i = ~clk_i;
   end
   function automatic logic [15:0] rev(input logic [15:0] a);
      return {a[3:0], a[7:4], a[11:8], a[15:12]};
   endfunction : rev
   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : complete_run
   task automatic chk(input logic [39:0] got, input logic [39:0] exp);
      n_tests++;
      if (got !== exp) begin
         failures++;
         $display("FAIL %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic cyc();
      @(posedge array_clk_o);
      @(negedge clk_i);
   endtask : cyc
   task automatic rd(input logic [3:0] n, input logic [15:0] e);
      {mem_addr_lo_i, data_src_load_i, mem_read_cfg_i, load_data_bit_n_i} = {n, 3'h2};
      cyc();
      chk(40'(mem_data_reg_o), 40'(e));
      mem_read_cfg_i = 1'b0;
   endtask : rd
   // the write cycle also reloads the data register: old value must still be written
   task automatic arr(input logic [3:0] n, input logic [15:0] d);
      {mem_addr_lo_i, data_src_load_i, data_bus_i, addr_bus_i} = {n, 1'b1, d, ~d};
      {load_addr_bit_n_i, load_page_bit_n_i, load_data_bit_n_i} = 3'h0;
      cyc();
      chk({24'h000000, mem_addr_reg_o}, {24'h000000, ~d});
      chk({32'h00000000, page_reg_o}, {32'h00000000, ~d[7:0]});
      {load_addr_bit_n_i, load_page_bit_n_i, array_write_i, data_bus_i} = {3'h7, ~d};
      cyc();
      array_write_i = 1'b0;
      rd(n, d);
   endtask : arr
   task automatic host(input logic wr, input logic [1:0] dsn, input logic [1:0] g, input logic [15:0] d);
      {memory_enable_n_i, mem_addr_lo_i, host_write_n_i, host_ds1_n_i, host_ds0_n_i} = {1'b1, g, 2'h0, !wr, dsn};
      {host_data_i, halt_i, host_window_hit_n_i} = {d, 2'h2};
      cyc();
      cyc();
      {memory_enable_n_i, halt_i, host_window_hit_n_i} = 3'h1;
      // let the window drop for a clock so back-to-back accesses stay distinct
      @(negedge clk_i);
   endtask : host
   task automatic pulse(input logic par, input logic blk);
      {ucode_read_i, ucode_write_i} = {blk & par, blk & !par};
      {par_copy_clk_n_i, shadow_chain_clk_n_i} = {!par, par};
      @(negedge clk_i);
      {par_copy_clk_n_i, shadow_chain_clk_n_i} = 2'h3;
      repeat (2) @(negedge clk_i);
      {ucode_read_i, ucode_write_i} = 2'h0;
      @(negedge clk_i);
   endtask : pulse
   task automatic load_chain(input logic [39:0] s);
      for (int k = 39; k >= 0; k--) begin
         chain_sdi_i = s[k];
         pulse(1'b0, 1'b0);
      end
   endtask : load_chain
   initial begin
      #200000;
      failures++;
      $display("FAIL %0t watchdog expired", $time);
      complete_run();
   end
   initial begin
      rst_i = 1'b1;
      {memory_enable_n_i, host_window_hit_n_i, host_io_match_n_i, halt_i, host_write_n_i} = 5'h0d;
      {host_ds0_n_i, host_ds1_n_i, array_write_i, mem_read_cfg_i, data_src_load_i} = 5'h18;
      {ucode_read_i, ucode_write_i, chain_sdi_i, load_addr_bit_n_i, load_page_bit_n_i} = 5'h03;
      {load_data_bit_n_i, copy_to_parallel_mode_n_i, copy_to_shadow_mode_n_i} = 3'h7;
      {par_copy_clk_n_i, shadow_chain_clk_n_i} = 2'h3;
      {mem_addr_lo_i, addr_bus_i, data_bus_i, host_data_i} = 52'h0;
      repeat (10) @(negedge clk_i);
      rst_i = 1'b0;
      // the divider raises the array clock once right after reset, before any load edge
      @(negedge array_clk_o);
      @(negedge clk_i);
      for (int i = 0; i < 12; i++) begin
         arr(4'(i < 3 ? 13 + i : $random(seed)), 16'($random(seed)));
      end
      $display("array access test done");
      for (int g = 0; g < 4; g++) begin
         v = 16'($random(seed));
         w = 16'($random(seed));
         arr({g[1:0], 2'h0}, v);
         host(1'b0, 2'h0, g[1:0], 16'h0000);
         chk(40'(host_data_o), 40'(rev(v)));
         host(1'b1, 2'h0, g[1:0], w);
         host(1'b1, 2'h2, g[1:0], ~w);
         rd({g[1:0], 2'h0}, rev({w[15:8], ~w[7:0]}));
      end
      $display("host access test done");
      {memory_enable_n_i, load_data_bit_n_i} = 2'h3;
      x = 40'({$random(seed), $random(seed)});
      load_chain(x);
      chk(40'(chain_sdo_o), 40'(x[39]));
      copy_to_parallel_mode_n_i = 1'b0;
      @(negedge clk_i);
      chk(40'(combined_mode_o), 40'h1);
      pulse(1'b1, 1'b0);
      copy_to_parallel_mode_n_i = 1'b1;
      chk({mem_data_reg_o, mem_addr_reg_o, page_reg_o}, x);
      load_chain(~x);
      copy_to_parallel_mode_n_i = 1'b0;
      @(negedge clk_i);
      pulse(1'b1, 1'b1);
      copy_to_parallel_mode_n_i = 1'b1;
      chk({mem_data_reg_o, mem_addr_reg_o, page_reg_o}, x);
      {copy_to_shadow_mode_n_i, chain_sdi_i} = 2'h0;
      repeat (40) @(negedge clk_i);
      pulse(1'b0, 1'b0);
      copy_to_shadow_mode_n_i = 1'b1;
      pulse(1'b0, 1'b1);
      for (int k = 39; k >= 0; k--) begin
         chk(40'(chain_sdo_o), 40'(x[k]));
         pulse(1'b0, 1'b0);
      end
      $display("serial chain test done");
      complete_run();
   end
endmodule : tb_top
`default_nettype wire

// [hw/adm_datapath.sv]
`timescale 1ns/1ps
`default_nettype none
module adm_datapath #(
   parameter int OSC_PER_CYCLE = adm_pkg::OSC_PER_ARRAY
) (
   input  wire logic                       clk_i,
   input  wire logic                       rst_i,
   input  wire logic [adm_pkg::AMT_W-1:0]  mem_addr_lo_i,
   input  wire logic                       memory_enable_n_i,
   input  wire logic                       host_window_hit_n_i,
   input  wire logic                       host_io_match_n_i,
   input  wire logic                       halt_i,
   input  wire logic                       host_write_n_i,
   input  wire logic                       host_ds0_n_i,
   input  wire logic                       host_ds1_n_i,
   input  wire logic                       array_write_i,
   input  wire logic                       mem_read_cfg_i,
   input  wire logic                       data_src_load_i,
   input  wire logic                       load_addr_bit_n_i,
   input  wire logic                       load_page_bit_n_i,
   input  wire logic                       load_data_bit_n_i,
   input  wire logic [adm_pkg::WORD_W-1:0] addr_bus_i,
   input  wire logic [adm_pkg::WORD_W-1:0] data_bus_i,
   input  wire logic [adm_pkg::RAM_W-1:0]  ram_data_i,
   input  wire logic [adm_pkg::WORD_W-1:0] host_data_i,
   input  wire logic                       copy_to_parallel_mode_n_i,
   input  wire logic                       copy_to_shadow_mode_n_i,
   input  wire logic                       par_copy_clk_n_i,
   input  wire logic                       shadow_chain_clk_n_i,
   input  wire logic                       ucode_read_i,
   input  wire logic                       ucode_write_i,
   input  wire logic                       chain_sdi_i,
   output logic                            chain_sdo_o,
   output logic                            array_clk_o,
   output logic                            mem_write_strobe_n_o,
   output logic [adm_pkg::NIBBLES-1:0]     chip_sel_o,
   output logic [adm_pkg::RAM_W-1:0]       ram_data_o,
   output logic                            wr_rot_oe_o,
   output logic                            rd_rot_oe_o,
   output logic                            host_xcvr_oe_o,
   output logic [adm_pkg::WORD_W-1:0]      host_data_o,
   output logic                            addr_reg_clock_o,
   output logic                            page_reg_clock_o,
   output logic                            data_reg_clock_o,
   output logic                            shadow_clock_o,
   output logic                            combined_mode_o,
   output logic [adm_pkg::WORD_W-1:0]      mem_addr_reg_o,
   output logic [adm_pkg::PAGE_W-1:0]      page_reg_o,
   output logic [adm_pkg::WORD_W-1:0]      mem_data_reg_o
);
   localparam int PH_W = $clog2(OSC_PER_CYCLE + 1);
   localparam logic [PH_W-1:0] PH_LAST = PH_W'(OSC_PER_CYCLE - 1);
   localparam logic [PH_W-1:0] PH_HALF = PH_W'(OSC_PER_CYCLE / 2);

   // array cycle phase, one count per oscillator period
   logic [PH_W-1:0] phase_q, phase_d;
   logic            arr_clk_q, arr_clk_d;

   // host access qualifiers, array clock edge and copy mode
   logic host_acc, host_strobe, array_rise;
   adm_pkg::adm_copy_mode_t mode;

   // edge history of the host copy clocks
   logic pcc_prev_q, pcc_prev_d, scc_prev_q, scc_prev_d;
   logic par_copy_rise, shadow_rise;

   // parallel and shadow registers
   logic [adm_pkg::WORD_W-1:0] addr_q, addr_d, data_q, data_d;
   logic [adm_pkg::PAGE_W-1:0] page_q, page_d;
   logic [adm_pkg::WORD_W-1:0] addr_sh_q, addr_sh_d, data_sh_q, data_sh_d;
   logic [adm_pkg::PAGE_W-1:0] page_sh_q, page_sh_d;
   logic [adm_pkg::WORD_W-1:0] data_norm;
   logic ld_addr, ld_page, ld_data;

   // registered outputs
   logic                         strobe_n_q, strobe_n_d;
   logic [adm_pkg::NIBBLES-1:0]  cs_q, cs_d;
   logic [adm_pkg::RAM_W-1:0]    ram_q, ram_d;
   logic                         wr_oe_q, wr_oe_d, rd_oe_q, rd_oe_d, xcvr_q, xcvr_d;
   logic [adm_pkg::WORD_W-1:0]   hdata_q, hdata_d;
   logic                         aclk_q, aclk_d, pclk_q, pclk_d, dclk_q, dclk_d, sclk_q, sclk_d;
   logic                         cmode_q, cmode_d;

   // rotator paths
   logic [adm_pkg::RAM_W-1:0]    rd_rot, wr_rot;
   logic [2*adm_pkg::NIBBLES-1:0] cs_wrap;
   logic [adm_pkg::GROUP_W-1:0]  grp;
   logic [adm_pkg::WORD_W-1:0]   grp_word;

   adm_rotator #(
      .NIB   (adm_pkg::NIB_W),
      .NIBS  (adm_pkg::NIBBLES),
      .AMT_W (adm_pkg::AMT_W)
   ) u_rd_rot (
      .data_i (ram_data_i),
      .amt_i  (mem_addr_lo_i),
      .left_i (1'b0),
      .data_o (rd_rot)
   );

   adm_rotator #(
      .NIB   (adm_pkg::NIB_W),
      .NIBS  (adm_pkg::NIBBLES),
      .AMT_W (adm_pkg::AMT_W)
   ) u_wr_rot (
      .data_i ({4{data_q}}),
      .amt_i  (mem_addr_lo_i),
      .left_i (1'b1),
      .data_o (wr_rot)
   );

   // shared decode
   always_comb begin
      host_acc      = !host_window_hit_n_i && halt_i && host_io_match_n_i;
      host_strobe   = !host_ds0_n_i || !host_ds1_n_i;
      array_rise    = (phase_q == PH_LAST);
      par_copy_rise = !pcc_prev_q && par_copy_clk_n_i;
      shadow_rise   = !scc_prev_q && shadow_chain_clk_n_i;
      if (!copy_to_parallel_mode_n_i) begin
         mode = adm_pkg::ADM_MODE_TO_PAR;
      end else if (!copy_to_shadow_mode_n_i) begin
         mode = adm_pkg::ADM_MODE_TO_SHADOW;
      end else begin
         mode = adm_pkg::ADM_MODE_NORMAL;
      end
   end

   // array clock divider
   always_comb begin
      phase_d   = array_rise ? '0 : phase_q + PH_W'(1);
      arr_clk_d = (phase_d < PH_HALF);
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         phase_q   <= '0;
         arr_clk_q <= 1'b0;
      end else begin
         phase_q   <= phase_d;
         arr_clk_q <= arr_clk_d;
      end
   end

   // register loading and the shadow chain
   always_comb begin
      ld_addr   = (array_rise && !load_addr_bit_n_i) || (par_copy_rise && !ucode_read_i);
      ld_page   = (array_rise && !load_page_bit_n_i) || (par_copy_rise && !ucode_read_i);
      ld_data   = (array_rise && !load_data_bit_n_i) || (par_copy_rise && !ucode_read_i);
      data_norm = data_src_load_i ? data_bus_i : rd_rot[adm_pkg::WORD_W-1:0];
      pcc_prev_d = par_copy_clk_n_i;
      scc_prev_d = shadow_chain_clk_n_i;
      addr_d    = addr_q;
      page_d    = page_q;
      data_d    = data_q;
      addr_sh_d = addr_sh_q;
      page_sh_d = page_sh_q;
      data_sh_d = data_sh_q;
      if (mode == adm_pkg::ADM_MODE_TO_PAR) begin
         if (ld_addr) addr_d = addr_sh_q;
         if (ld_page) page_d = page_sh_q;
         if (ld_data) data_d = data_sh_q;
      end else begin
         if (ld_addr) addr_d = addr_bus_i;
         if (ld_page) page_d = addr_bus_i[adm_pkg::PAGE_W-1:0];
         if (ld_data) data_d = data_norm;
      end
      if (shadow_rise && !ucode_write_i) begin
         case (mode)
            adm_pkg::ADM_MODE_NORMAL: begin
               page_sh_d = {page_sh_q[adm_pkg::PAGE_W-2:0], chain_sdi_i};
               addr_sh_d = {addr_sh_q[adm_pkg::WORD_W-2:0], page_sh_q[adm_pkg::PAGE_W-1]};
               data_sh_d = {data_sh_q[adm_pkg::WORD_W-2:0], addr_sh_q[adm_pkg::WORD_W-1]};
            end
            adm_pkg::ADM_MODE_TO_SHADOW: begin
               page_sh_d = page_q;
               addr_sh_d = addr_q;
               data_sh_d = data_q;
            end
            default: begin
               page_sh_d = page_sh_q;
            end
         endcase
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         pcc_prev_q <= 1'b1;
         scc_prev_q <= 1'b1;
         addr_q     <= adm_pkg::WORD_RESET;
         page_q     <= adm_pkg::PAGE_RESET;
         data_q     <= adm_pkg::WORD_RESET;
         addr_sh_q  <= adm_pkg::WORD_RESET;
         page_sh_q  <= adm_pkg::PAGE_RESET;
         data_sh_q  <= adm_pkg::WORD_RESET;
      end else begin
         pcc_prev_q <= pcc_prev_d;
         scc_prev_q <= scc_prev_d;
         addr_q     <= addr_d;
         page_q     <= page_d;
         data_q     <= data_d;
         addr_sh_q  <= addr_sh_d;
         page_sh_q  <= page_sh_d;
         data_sh_q  <= data_sh_d;
      end
   end

   // memory strobes, selects, rotator and transceiver enables
   always_comb begin
      grp      = mem_addr_lo_i[adm_pkg::AMT_W-1 -: adm_pkg::GROUP_W];
      grp_word = ram_data_i[int'(grp)*adm_pkg::WORD_W +: adm_pkg::WORD_W];
      // strobe only in the last period so address and selects settle first
      strobe_n_d = !((array_write_i || (host_acc && host_strobe && !host_write_n_i))
                     && (phase_d == PH_LAST));
      cs_wrap = {adm_pkg::CS_WORD_MASK, adm_pkg::CS_WORD_MASK} << mem_addr_lo_i;
      if (host_acc && host_strobe) begin
         cs_d = adm_pkg::CS_NONE;
         if (!host_ds1_n_i) begin
            cs_d = cs_d | (adm_pkg::CS_UPPER_BYTE << (int'(grp) * 4));
         end
         if (!host_ds0_n_i) begin
            cs_d = cs_d | (adm_pkg::CS_LOWER_BYTE << (int'(grp) * 4));
         end
      end else if (!memory_enable_n_i && !host_acc) begin
         cs_d = cs_wrap[2*adm_pkg::NIBBLES-1 -: adm_pkg::NIBBLES];
      end else begin
         cs_d = adm_pkg::CS_NONE;
      end
      wr_oe_d = !strobe_n_d && !host_acc;
      rd_oe_d = mem_read_cfg_i && !data_src_load_i && !host_acc;
      if (host_acc) begin
         xcvr_d = host_write_n_i ? 1'b1 : !strobe_n_d;
      end else begin
         xcvr_d = 1'b0;
      end
      // host words sit in one chip group, upper byte in the lower chips
      hdata_d = {grp_word[3:0], grp_word[7:4], grp_word[11:8], grp_word[15:12]};
      ram_d   = wr_rot;
      if (host_acc) begin
         ram_d = ram_q;
         ram_d[int'(grp)*adm_pkg::WORD_W +: adm_pkg::WORD_W] =
            {host_data_i[3:0], host_data_i[7:4], host_data_i[11:8], host_data_i[15:12]};
      end
      aclk_d  = ld_addr;
      pclk_d  = ld_page;
      dclk_d  = ld_data;
      sclk_d  = shadow_rise && !ucode_write_i;
      cmode_d = (mode != adm_pkg::ADM_MODE_NORMAL);
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         strobe_n_q <= 1'b1;
         cs_q       <= adm_pkg::CS_NONE;
         ram_q      <= adm_pkg::RAM_RESET;
         wr_oe_q    <= 1'b0;
         rd_oe_q    <= 1'b0;
         xcvr_q     <= 1'b0;
         hdata_q    <= adm_pkg::WORD_RESET;
         aclk_q     <= 1'b0;
         pclk_q     <= 1'b0;
         dclk_q     <= 1'b0;
         sclk_q     <= 1'b0;
         cmode_q    <= 1'b0;
      end else begin
         strobe_n_q <= strobe_n_d;
         cs_q       <= cs_d;
         ram_q      <= ram_d;
         wr_oe_q    <= wr_oe_d;
         rd_oe_q    <= rd_oe_d;
         xcvr_q     <= xcvr_d;
         hdata_q    <= hdata_d;
         aclk_q     <= aclk_d;
         pclk_q     <= pclk_d;
         dclk_q     <= dclk_d;
         sclk_q     <= sclk_d;
         cmode_q    <= cmode_d;
      end
   end

   assign chain_sdo_o          = data_sh_q[adm_pkg::WORD_W-1];
   assign array_clk_o          = arr_clk_q;
   assign mem_write_strobe_n_o = strobe_n_q;
   assign chip_sel_o           = cs_q;
   assign ram_data_o           = ram_q;
   assign wr_rot_oe_o          = wr_oe_q;
   assign rd_rot_oe_o          = rd_oe_q;
   assign host_xcvr_oe_o       = xcvr_q;
   assign host_data_o          = hdata_q;
   assign addr_reg_clock_o     = aclk_q;
   assign page_reg_clock_o     = pclk_q;
   assign data_reg_clock_o     = dclk_q;
   assign shadow_clock_o       = sclk_q;
   assign combined_mode_o      = cmode_q;
   assign mem_addr_reg_o       = addr_q;
   assign page_reg_o           = page_q;
   assign mem_data_reg_o       = data_q;
endmodule : adm_datapath
`default_nettype wire

// [hw/adm_rotator.sv]
`timescale 1ns/1ps
`default_nettype none
// nibble barrel rotator; left rotation is done as right by the negated amount
module adm_rotator #(
   parameter int NIB   = 4,
   parameter int NIBS  = 16,
   parameter int AMT_W = 4
) (
   input  wire logic [NIB*NIBS-1:0] data_i,
   input  wire logic [AMT_W-1:0]    amt_i,
   input  wire logic                left_i,
   output logic      [NIB*NIBS-1:0] data_o
);
   logic [AMT_W-1:0]        sh;
   logic [2*NIB*NIBS-1:0]   dbl;

   always_comb begin
      sh     = left_i ? AMT_W'(-amt_i) : amt_i;
      dbl    = {data_i, data_i} >> (int'(sh) * NIB);
      data_o = dbl[NIB*NIBS-1:0];
   end
endmodule : adm_rotator
`default_nettype wire

// [shared/adm_pkg.sv]
package adm_pkg;
   localparam int NIB_W         = 4;
   localparam int NIBBLES       = 16;
   localparam int RAM_W         = NIB_W * NIBBLES;
   localparam int WORD_W        = 16;
   localparam int PAGE_W        = 8;
   localparam int AMT_W         = 4;
   localparam int GROUP_W       = 2;
   localparam int OSC_PERIOD_NS = 20;
   localparam int ARRAY_CLK_NS  = 160;
   localparam int OSC_PER_ARRAY = (ARRAY_CLK_NS + OSC_PERIOD_NS - 1) / OSC_PERIOD_NS;
   localparam logic [NIBBLES-1:0] CS_NONE      = 16'h0000;
   localparam logic [NIBBLES-1:0] CS_WORD_MASK = 16'h000f;
   localparam logic [NIBBLES-1:0] CS_UPPER_BYTE = 16'h0003;
   localparam logic [NIBBLES-1:0] CS_LOWER_BYTE = 16'h000c;
   localparam logic [WORD_W-1:0]  WORD_RESET   = 16'h0000;
   localparam logic [PAGE_W-1:0]  PAGE_RESET   = 8'h00;
   localparam logic [RAM_W-1:0]   RAM_RESET    = 64'h0000_0000_0000_0000;

   typedef enum logic [1:0] {
      ADM_MODE_NORMAL    = 2'b00,
      ADM_MODE_TO_PAR    = 2'b01,
      ADM_MODE_TO_SHADOW = 2'b10
   } adm_copy_mode_t;
endpackage : adm_pkg
